/* File: common/tbrc_map.svh */
`ifndef TBRC_MAP_SVH
`define TBRC_MAP_SVH

`define TBRC_ADDR_CTRL1 16'h0020
`define TBRC_ADDR_STATUS 16'h0021
`define TBRC_ADDR_TRCTL 16'h0022
`define TBRC_ADDR_WINDOW 16'h0024
`define TBRC_ADDR_WINDOW_HI 16'h0025
`define TBRC_ADDR_COUNT 16'h0026
`define TBRC_ADDR_SHARED 16'h0027

`define TBRC_CTRL1_ARM 7
`define TBRC_CTRL1_SEL_HI 1
`define TBRC_CTRL1_SEL_LO 0
`define TBRC_TRCTL_TSRC 6
`define TBRC_TRCTL_ALIGN 0
`define TBRC_FULL_BIT 7

`define TBRC_SEL_STATE_ONE 2'h0
`define TBRC_SEL_STATE_TWO 2'h1
`define TBRC_SEL_STATE_THREE 2'h2
`define TBRC_SEL_MATCH_FLAGS 2'h3

`define TBRC_LINE_LAST 6'h3F
`define TBRC_RESET_SCR 4'h0
`define TBRC_RESET_DATA 16'h0000

`endif

/* File: common/tbrc_pkg.sv */
package tbrc_pkg;

	typedef enum logic [2:0] {
		TBRC_ST_IDLE = 3'b000,
		TBRC_ST_ONE = 3'b001,
		TBRC_ST_TWO = 3'b010,
		TBRC_ST_THREE = 3'b011,
		TBRC_ST_FINAL = 3'b100
	} tbrc_seq_t;

	typedef struct packed {
		logic full;
		logic [5:0] count;
	} tbrc_cnt_t;

	typedef struct packed {
		logic arm;
		logic [1:0] sel;
		logic tsrc;
		logic align;
		tbrc_seq_t seq;
		logic [3:0] scr1;
		logic [3:0] scr2;
		logic [3:0] scr3;
		logic unlocked;
		logic [5:0] rdPtr;
		logic rdHalf;
		logic [15:0] rdData;
	} tbrc_main_t;

endpackage

/* File: rtl/tbrc_trace_mem.sv */
`timescale 1ns/100ps
module tbrc_trace_mem
	import tbrc_pkg::*;
(
	input wire logic clock,
	input wire logic writeEn,
	input wire logic [5:0] writeAddr,
	input wire logic [19:0] writeData,
	input wire logic [5:0] readAddr,
	output logic [19:0] readData
);
	// no reset at all: lines survive every reset, power-on leaves them undefined
	logic [19:0] lines [0:63];

	always_ff @(posedge clock) begin
		if (writeEn) begin
			lines[writeAddr] <= writeData;
		end
	end

	assign readData = lines[readAddr];
endmodule

/* File: rtl/tbrc_line_counter.sv */
`timescale 1ns/100ps
`include "tbrc_map.svh"
module tbrc_line_counter
	import tbrc_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic armPulse,
	input wire logic lineStore,
	input wire logic beginAlign,
	output logic [5:0] count,
	output logic full,
	output logic wrapEnd
);
	tbrc_cnt_t st;
	tbrc_cnt_t next_st;
	logic wrap;

	assign wrap = lineStore && !armPulse && (st.count == `TBRC_LINE_LAST);

	always_comb begin
		next_st = st;
		if (armPulse) begin
			next_st.count = 6'h00;
		end else if (lineStore) begin
			next_st.count = st.count + 6'h01;
		end
		// a store in the arming cycle is no wrap: arming clears full
		next_st.full = (st.full && !armPulse) || wrap;
	end

	// only power-on reset reaches here; other resets keep count and flag
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign count = st.count;
	assign full = st.full;
	assign wrapEnd = wrap && beginAlign;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	a_wrap_sets_full: assert property (wrap |=> full && count == 6'h00)
		else $error("wrap did not set full flag");
	a_arm_clears_all: assert property (armPulse && !lineStore |=> !full && count == 6'h00)
		else $error("arming did not clear count and full flag");
	a_count_steps: assert property (lineStore && !armPulse |=> count == $past(count) + 6'h01)
		else $error("count did not step on a stored line");
endmodule

/* File: rtl/tbrc_top.sv */
`timescale 1ns/100ps
`include "tbrc_map.svh"
// Overview of operation
// - 20-bit lines read through 16-bit window
// - every second valid window read (upper half) advances pointer
// - valid read: unlocked, unsecured, disarmed, source enabled
// - arming locks buffer against reading
// - disarmed aligned word write unlocks, data kept
// - byte or misaligned reads give zero
// - armed or source-off reads give zero
// - lines survive resets, undefined after power-on
// - full flag after 64 stored lines
// - full cleared by arming and power-on only
// - full flag bit 7 in two registers
// - count field bits 5..0 holds valid lines
// - wrap sets full, end-align keeps counting
// - count cleared by arming and power-on only
// - reading buffer never changes count
// - begin-align wrap ends session, clears arm
// - full with nonzero count: oldest overwritten
// - count register read-only, writes ignored
// - select 00/01/10 picks state controls
// - select 11 shows match flag register
// - state control steers leaving each state
// - alignment bit: 0 end, 1 begin
// - arming enters state one, indication 001
module tbrc_top
	import tbrc_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic sysReset,
	input wire logic [15:0] busAddr,
	input wire logic [15:0] busWdata,
	input wire logic busWrite,
	input wire logic busRead,
	input wire logic busWord,
	output logic [15:0] busRdata,
	input wire logic partSecured,
	input wire logic lineStore,
	input wire logic [19:0] lineData,
	input wire logic [7:0] matchFlags,
	input wire logic seqStep,
	input wire logic [2:0] seqNext,
	output logic sessionArmed,
	output logic traceEnable,
	output logic beginAlign,
	output logic [2:0] sequencerState,
	output logic [3:0] stateControl
);
	tbrc_main_t st;
	tbrc_main_t next_st;
	logic [5:0] count;
	logic full;
	logic wrapEnd;
	logic [19:0] memLine;
	logic armPulse;
	logic store;
	logic winHit;
	logic winValid;
	logic [7:0] statusByte;
	logic [7:0] countByte;
	logic [7:0] sharedByte;

	assign store = lineStore && st.arm && st.tsrc;
	assign armPulse = busWrite && busAddr == `TBRC_ADDR_CTRL1 && busWdata[`TBRC_CTRL1_ARM];
	assign winHit = busAddr == `TBRC_ADDR_WINDOW && busWord;
	assign winValid = busRead && winHit && st.unlocked && !partSecured
		&& !st.arm && st.tsrc;

	tbrc_trace_mem u_mem (
		.clock(clock),
		.writeEn(store),
		.writeAddr(count),
		.writeData(lineData),
		.readAddr(st.rdPtr),
		.readData(memLine)
	);

	tbrc_line_counter u_count (
		.clock(clock),
		.reset_n(reset_n),
		.armPulse(armPulse),
		.lineStore(store),
		.beginAlign(st.align),
		.count(count),
		.full(full),
		.wrapEnd(wrapEnd)
	);

	assign statusByte = {full, 4'h0, st.seq};
	assign countByte = {full, 1'b0, count};

	always_comb begin
		case (st.sel)
			`TBRC_SEL_STATE_ONE: sharedByte = {4'h0, st.scr1};
			`TBRC_SEL_STATE_TWO: sharedByte = {4'h0, st.scr2};
			`TBRC_SEL_STATE_THREE: sharedByte = {4'h0, st.scr3};
			default: sharedByte = matchFlags;
		endcase
	end

	always_comb begin
		next_st = st;
		// read answers: every read reloads the data register, misses read zero
		if (busRead) begin
			next_st.rdData = `TBRC_RESET_DATA;
			case (busAddr)
				`TBRC_ADDR_CTRL1: next_st.rdData = {8'h00, st.arm, 5'h00, st.sel};
				`TBRC_ADDR_STATUS: next_st.rdData = {8'h00, statusByte};
				`TBRC_ADDR_TRCTL: next_st.rdData = {8'h00, 1'b0, st.tsrc, 5'h00, st.align};
				`TBRC_ADDR_COUNT: next_st.rdData = {8'h00, countByte};
				`TBRC_ADDR_SHARED: next_st.rdData = {8'h00, sharedByte};
				default: next_st.rdData = `TBRC_RESET_DATA;
			endcase
			if (winValid) begin
				// low sixteen bits first, then the top four in the low nibble
				if (!st.rdHalf) begin
					next_st.rdData = memLine[15:0];
				end else begin
					next_st.rdData = {12'h000, memLine[19:16]};
					next_st.rdPtr = st.rdPtr + 6'h01;
				end
				next_st.rdHalf = !st.rdHalf;
			end
		end
		if (busWrite) begin
			case (busAddr)
				`TBRC_ADDR_CTRL1: begin
					next_st.sel = busWdata[`TBRC_CTRL1_SEL_HI:`TBRC_CTRL1_SEL_LO];
					if (busWdata[`TBRC_CTRL1_ARM]) begin
						next_st.arm = 1'b1;
						next_st.unlocked = 1'b0;
						next_st.seq = TBRC_ST_ONE;
					end else begin
						// software disarm keeps the last sequencer state visible
						next_st.arm = 1'b0;
					end
				end
				`TBRC_ADDR_TRCTL: begin
					if (!st.arm) begin
						next_st.align = busWdata[`TBRC_TRCTL_ALIGN];
						if (!partSecured) begin
							next_st.tsrc = busWdata[`TBRC_TRCTL_TSRC];
						end
					end
				end
				`TBRC_ADDR_WINDOW: begin
					if (busWord && !st.arm) begin
						next_st.unlocked = 1'b1;
						// when full the write slot holds the oldest line
						next_st.rdPtr = full ? count : 6'h00;
						next_st.rdHalf = 1'b0;
					end
				end
				`TBRC_ADDR_SHARED: begin
					if (!st.arm) begin
						case (st.sel)
							`TBRC_SEL_STATE_ONE: next_st.scr1 = busWdata[3:0];
							`TBRC_SEL_STATE_TWO: next_st.scr2 = busWdata[3:0];
							`TBRC_SEL_STATE_THREE: next_st.scr3 = busWdata[3:0];
							default: next_st.scr1 = st.scr1;
						endcase
					end
				end
				// count register and status ignore writes
				default: next_st.arm = next_st.arm;
			endcase
		end
		if (st.arm && seqStep && !armPulse) begin
			next_st.seq = tbrc_seq_t'(seqNext);
		end
		if (wrapEnd) begin
			next_st.arm = 1'b0;
			next_st.seq = TBRC_ST_IDLE;
		end
		// other resets: buffer lock and pointer stay, count lives elsewhere
		if (sysReset) begin
			next_st.arm = 1'b0;
			next_st.sel = 2'h0;
			next_st.tsrc = 1'b0;
			next_st.align = 1'b0;
			next_st.seq = TBRC_ST_IDLE;
			next_st.scr1 = `TBRC_RESET_SCR;
			next_st.scr2 = `TBRC_RESET_SCR;
			next_st.scr3 = `TBRC_RESET_SCR;
			next_st.rdData = `TBRC_RESET_DATA;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign busRdata = st.rdData;
	assign sessionArmed = st.arm;
	assign traceEnable = st.tsrc;
	assign beginAlign = st.align;
	assign sequencerState = st.seq;

	// the capture sequencer outside reads the control of the current state
	always_comb begin
		case (st.seq)
			TBRC_ST_ONE: stateControl = st.scr1;
			TBRC_ST_TWO: stateControl = st.scr2;
			TBRC_ST_THREE: stateControl = st.scr3;
			default: stateControl = 4'h0;
		endcase
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n || sysReset);

	a_arm_locks: assert property (armPulse |=> !st.unlocked && sessionArmed)
		else $error("arming left the buffer unlocked");
	a_unlock_write: assert property (busWrite && winHit && !st.arm |=> st.unlocked && !st.rdHalf
		&& st.rdPtr == ($past(full) ? $past(count) : 6'h00))
		else $error("word write did not unlock at oldest line");
	a_byte_read_zero: assert property (busRead && busAddr == `TBRC_ADDR_WINDOW && !busWord
		|=> busRdata == 16'h0000 && $stable(st.rdPtr) && $stable(st.rdHalf))
		else $error("byte window read not zero or moved pointer");
	a_armed_read_zero: assert property (busRead && winHit && (st.arm || !st.tsrc)
		|=> busRdata == 16'h0000 && $stable(st.rdPtr))
		else $error("blocked window read not zero or moved pointer");
	a_half_advance: assert property (winValid && st.rdHalf
		|=> st.rdPtr == $past(st.rdPtr) + 6'h01 && !st.rdHalf && busRdata[15:4] == 12'h000)
		else $error("second half read did not advance pointer");
	a_low_half: assert property (winValid && !st.rdHalf
		|=> busRdata == $past(memLine[15:0]) && st.rdHalf)
		else $error("first half read returned wrong data");
	a_read_keeps_count: assert property (winValid && !store && !armPulse |=> $stable(count))
		else $error("reading the buffer changed the count");
	a_count_no_write: assert property (busWrite && busAddr == `TBRC_ADDR_COUNT && !store
		&& !armPulse |=> $stable(count) && $stable(full))
		else $error("write changed the count register");
	a_full_views: assert property (busRead && busAddr == `TBRC_ADDR_STATUS
		|=> busRdata[`TBRC_FULL_BIT] == $past(countByte[`TBRC_FULL_BIT]))
		else $error("full flag views disagree");
	a_begin_end: assert property (wrapEnd |=> !sessionArmed && sequencerState == 3'b000)
		else $error("begin alignment wrap did not end session");
	a_arm_state: assert property (armPulse && !wrapEnd |=> sequencerState == 3'b001)
		else $error("arming did not enter state one");

	c_full_read: cover property (winValid && full);
	c_two_halves: cover property (winValid && !st.rdHalf ##[1:20] winValid && st.rdHalf);
	c_begin_end: cover property (wrapEnd);
	c_match_view: cover property (busRead && busAddr == `TBRC_ADDR_SHARED && st.sel == 2'h3);
endmodule

/* File: tb/trace_buffer_readout_and_count_tb_top.sv */
`timescale 1ns/100ps
`include "tbrc_map.svh"
module trace_buffer_readout_and_count_tb_top
	import tbrc_pkg::*;
;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic sysReset = 1'b0;
	logic [15:0] busAddr = 16'h0000;
	logic [15:0] busWdata = 16'h0000;
	logic busWrite = 1'b0;
	logic busRead = 1'b0;
	logic busWord = 1'b1;
	logic partSecured = 1'b0;
	logic lineStore = 1'b0;
	logic [19:0] lineData = 20'h00000;
	logic [7:0] matchFlags = 8'hC3;
	logic seqStep = 1'b0;
	logic [2:0] seqNext = 3'h0;
	logic [15:0] busRdata;
	logic sessionArmed;
	logic traceEnable;
	logic beginAlign;
	logic [2:0] sequencerState;
	logic [3:0] stateControl;
	logic [3:0] scr [3] = '{4'h3, 4'h6, 4'h9};
	int nFail = 0;
	int cmpCount = 0;

	tbrc_top DUT (.clock(clock), .reset_n(reset_n), .sysReset(sysReset),
		.busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite),
		.busRead(busRead), .busWord(busWord), .busRdata(busRdata),
		.partSecured(partSecured), .lineStore(lineStore), .lineData(lineData),
		.matchFlags(matchFlags), .seqStep(seqStep), .seqNext(seqNext),
		.sessionArmed(sessionArmed), .traceEnable(traceEnable),
		.beginAlign(beginAlign), .sequencerState(sequencerState),
		.stateControl(stateControl));

	initial begin
		forever #12.5 clock = ~clock;
	end

	// line i is easy to recognise in either half
	function automatic logic [15:0] lo(input int i);
		return {10'h2A5, 6'(i)};
	endfunction

	function automatic logic [15:0] hi(input int i);
		return {12'h000, 4'(i) ^ 4'h9};
	endfunction

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			nFail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clock);
		busAddr <= a;
		busWdata <= d;
		busWrite <= 1'b1;
		@(posedge clock);
		busWrite <= 1'b0;
	endtask

	// read data stand from the cycle after the strobe until the next read
	task automatic rc(input logic [15:0] a, input logic w, input logic [15:0] e, input string nm);
		@(posedge clock);
		busAddr <= a;
		busWord <= w;
		busRead <= 1'b1;
		@(posedge clock);
		busRead <= 1'b0;
		busWord <= 1'b1;
		#1;
		chk(nm, busRdata, e);
	endtask

	task automatic store(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clock);
			lineStore <= 1'b1;
			lineData <= {4'(i) ^ 4'h9, lo(i)};
		end
		@(posedge clock);
		lineStore <= 1'b0;
	endtask

	task conclude;
		if (nFail == 0 && cmpCount > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		#500000;
		nFail++;
		conclude();
	end

	initial begin
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		rc(`TBRC_ADDR_COUNT, 1'b1, 16'h0000, "count at start");
		for (int s = 0; s < 3; s++) begin
			wr(`TBRC_ADDR_CTRL1, 16'(s));
			wr(`TBRC_ADDR_SHARED, {12'h000, scr[s]});
			rc(`TBRC_ADDR_SHARED, 1'b1, {12'h000, scr[s]}, "state control");
		end
		wr(`TBRC_ADDR_CTRL1, 16'h0003);
		wr(`TBRC_ADDR_SHARED, 16'h0055);
		rc(`TBRC_ADDR_SHARED, 1'b1, 16'h00C3, "match flags");
		wr(`TBRC_ADDR_TRCTL, 16'h0040);
		wr(`TBRC_ADDR_CTRL1, 16'h0080);
		#1;
		chk("armed", sessionArmed, 16'h0001);
		chk("control in first state", stateControl, 16'h0003);
		chk("source enable pin", traceEnable, 16'h0001);
		chk("end alignment pin", beginAlign, 16'h0000);
		chk("state pin on arming", sequencerState, 16'h0001);
		rc(`TBRC_ADDR_STATUS, 1'b1, 16'h0001, "first state");
		@(posedge clock);
		seqStep <= 1'b1;
		seqNext <= 3'h2;
		@(posedge clock);
		seqStep <= 1'b0;
		#1;
		chk("control in second state", stateControl, 16'h0006);
		chk("state pin after step", sequencerState, 16'h0002);
		store(5);
		rc(`TBRC_ADDR_COUNT, 1'b1, 16'h0005, "count five");
		rc(`TBRC_ADDR_WINDOW, 1'b1, 16'h0000, "armed read");
		wr(`TBRC_ADDR_CTRL1, 16'h0000);
		rc(`TBRC_ADDR_WINDOW, 1'b1, 16'h0000, "locked read");
		wr(`TBRC_ADDR_WINDOW, 16'hFFFF);
		rc(`TBRC_ADDR_WINDOW, 1'b0, 16'h0000, "byte read");
		rc(`TBRC_ADDR_WINDOW_HI, 1'b1, 16'h0000, "misaligned read");
		rc(`TBRC_ADDR_WINDOW, 1'b1, lo(0), "line0 low");
		rc(`TBRC_ADDR_WINDOW, 1'b1, hi(0), "line0 high");
		rc(`TBRC_ADDR_WINDOW, 1'b1, lo(1), "line1 low");
		@(posedge clock);
		partSecured <= 1'b1;
		rc(`TBRC_ADDR_WINDOW, 1'b1, 16'h0000, "secured read");
		@(posedge clock);
		partSecured <= 1'b0;
		rc(`TBRC_ADDR_WINDOW, 1'b1, hi(1), "line1 high");
		wr(`TBRC_ADDR_TRCTL, 16'h0000);
		rc(`TBRC_ADDR_WINDOW, 1'b1, 16'h0000, "source off read");
		wr(`TBRC_ADDR_TRCTL, 16'h0040);
		rc(`TBRC_ADDR_WINDOW, 1'b1, lo(2), "line2 low");
		rc(`TBRC_ADDR_COUNT, 1'b1, 16'h0005, "count after reads");
		wr(`TBRC_ADDR_COUNT, 16'h0011);
		rc(`TBRC_ADDR_COUNT, 1'b1, 16'h0005, "count after write");
		wr(`TBRC_ADDR_CTRL1, 16'h0080);
		rc(`TBRC_ADDR_COUNT, 1'b1, 16'h0000, "count on arming");
		store(66);
		rc(`TBRC_ADDR_COUNT, 1'b1, 16'h0082, "count after wrap");
		rc(`TBRC_ADDR_STATUS, 1'b1, 16'h0081, "status full");
		@(posedge clock);
		sysReset <= 1'b1;
		@(posedge clock);
		sysReset <= 1'b0;
		rc(`TBRC_ADDR_COUNT, 1'b1, 16'h0082, "count after system reset");
		chk("armed after system reset", sessionArmed, 16'h0000);
		chk("source after system reset", traceEnable, 16'h0000);
		wr(`TBRC_ADDR_TRCTL, 16'h0040);
		wr(`TBRC_ADDR_WINDOW, 16'h0000);
		rc(`TBRC_ADDR_WINDOW, 1'b1, lo(2), "oldest low");
		rc(`TBRC_ADDR_WINDOW, 1'b1, hi(2), "oldest high");
		wr(`TBRC_ADDR_TRCTL, 16'h0041);
		wr(`TBRC_ADDR_CTRL1, 16'h0080);
		store(64);
		repeat (2) @(posedge clock);
		#1;
		chk("begin aligned session end", sessionArmed, 16'h0000);
		chk("state pin after begin wrap", sequencerState, 16'h0000);
		chk("begin alignment pin", beginAlign, 16'h0001);
		rc(`TBRC_ADDR_STATUS, 1'b1, 16'h0080, "status after begin wrap");
		@(posedge clock);
		reset_n <= 1'b0;
		@(posedge clock);
		reset_n <= 1'b1;
		rc(`TBRC_ADDR_COUNT, 1'b1, 16'h0000, "count after power on");
		conclude();
	end
endmodule
